/* hw/ccs_pkg.sv */
// constants, types and register map of the configuration cycle sequencer
package ccs_pkg;
	// clock and time figures
	localparam int REF_CLK_MHZ = 100;
	localparam int POR_FAST_MS = 3;
	localparam int POR_STD_MS = 50;
	localparam int ERR_TMO_US = 230;
	localparam int OSC_MHZ = 10;
	localparam int POR_FAST_CYC = POR_FAST_MS * 1000 * REF_CLK_MHZ;
	localparam int POR_STD_CYC = POR_STD_MS * 1000 * REF_CLK_MHZ;
	localparam int ERR_TMO_CYC = ERR_TMO_US * REF_CLK_MHZ;
	localparam int OSC_DIV = REF_CLK_MHZ / OSC_MHZ;
	localparam int INIT_CYC_BASE = 3185;
	localparam int INIT_CYC_SECURE = 3192;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LEN = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_BITS = 8'h0c;

	// values after reset
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [31:0] LEN_RST = 32'h0000_1000;
	// frame sync word, value arbitrary
	localparam logic [15:0] SYNC_WORD = 16'ha55a;
	localparam logic [4:0] HDR_BITS = 5'h10;

	// scheme select codes
	localparam logic [3:0] SEL_AS_STD_A = 4'h2;
	localparam logic [3:0] SEL_AS_STD_B = 4'h3;
	localparam logic [3:0] SEL_AS_FAST_A = 4'hd;
	localparam logic [3:0] SEL_AS_FAST_B = 4'h4;
	localparam logic [3:0] SEL_AP_STD_A = 4'h7;
	localparam logic [3:0] SEL_AP_STD_B = 4'hb;
	localparam logic [3:0] SEL_AP_STD_C = 4'h8;
	localparam logic [3:0] SEL_AP_FAST_A = 4'h5;
	localparam logic [3:0] SEL_AP_FAST_B = 4'h6;
	localparam logic [3:0] SEL_PS_STD = 4'h0;
	localparam logic [3:0] SEL_PS_FAST = 4'hc;
	localparam logic [3:0] SEL_FPP_A = 4'he;
	localparam logic [3:0] SEL_FPP_B = 4'hf;
	localparam logic [3:0] SEL_FPP_C = 4'h1;

	// captured word widths
	localparam logic [4:0] W_SERIAL = 5'd1;
	localparam logic [4:0] W_BYTE = 5'd8;
	localparam logic [4:0] W_WORD = 5'd16;

	// software control fields
	typedef struct packed {
		logic init_done_en;
		logic user_clk_en;
		logic auto_restart;
	} ccs_ctrl_t;

	typedef enum logic [5:0] {
		ST_POR = 6'b000001,
		ST_RESET = 6'b000010,
		ST_CONFIG = 6'b000100,
		ST_ERROR = 6'b001000,
		ST_INIT = 6'b010000,
		ST_USER = 6'b100000
	} ccs_state_t;
endpackage

/* hw/ccs_top.sv */
// configuration cycle sequencer with wishbone register slave
// Summary of operation
// - stay in reset while restart input or status line is sampled low.
// - hold power-on reset 3-9 ms fast or 50-200 ms standard.
// - during power-on reset drive status and load-complete low, tri-state user I/O.
// - active serial or parallel schemes keep driving configuration bus during power-on reset, except while chain enable is high and restart low.
// - after power-on reset keep I/O tri-stated, release status, enter configuration.
// - restart rising releases status; released status means ready for data.
// - weak pull-ups on user I/O after power-on reset and during configuration.
// - capture a word on every configuration clock cycle, width set by scheme.
// - release load-complete after all data; its rise starts initialization.
// - restart low resets, drives status and load-complete low, tri-states I/O.
// - a frame error drives status low and keeps load-complete low.
// - with auto restart, release status within 230 us and retry.
// - by default initialization runs from internal 10 MHz oscillator.
// - user clock option makes initialization run only from the user clock pin.
// - count 3185 initialization clocks, 3192 on the secure variant.
// - init-done floats early, driven low once the first frame's sync word checks good, released at user mode.
// - user mode hands I/O to the design and drops weak pull-ups.
// - scheme pins choose fast or standard power-on reset delay.
// - boundary-scan configuration overrides scheme pins for scheme choice.
`timescale 1ns/1ps
module ccs_top #(
	parameter int POR_FAST_CYCLES = ccs_pkg::POR_FAST_CYC,
	parameter int POR_STD_CYCLES = ccs_pkg::POR_STD_CYC,
	parameter int ERR_TMO_CYCLES = ccs_pkg::ERR_TMO_CYC,
	parameter bit SECURE = 1'b0,
	parameter int INIT_CYCLES = SECURE ? ccs_pkg::INIT_CYC_SECURE : ccs_pkg::INIT_CYC_BASE
) (
	input wire logic REF_CLK, // 100 MHz reference clock
	input wire logic RST_B, // asynchronous reset, active low
	input wire logic [7:0] WB_ADR_I, // wishbone byte address
	input wire logic [31:0] WB_DAT_I, // wishbone write data
	output logic [31:0] WB_DAT_O, // wishbone read data
	input wire logic [3:0] WB_SEL_I, // wishbone byte enables
	input wire logic WB_WE_I, // wishbone write enable
	input wire logic WB_CYC_I, // wishbone cycle
	input wire logic WB_STB_I, // wishbone strobe
	output logic WB_ACK_O, // wishbone acknowledge
	input wire logic RESTART_N, // restart input, active low
	input wire logic CHAIN_ENABLE_N, // chain enable, active low
	input wire logic [3:0] SCHEME_SELECT, // scheme select straps
	input wire logic JTAG_CFG_SEL, // boundary-scan configuration in use
	input wire logic CFG_BIT_CLOCK, // configuration data clock
	input wire logic [15:0] CFG_DATA, // configuration data bus
	input wire logic USER_INIT_CLOCK, // user initialization clock
	input wire logic STATUS_N_I, // status line level
	output logic STATUS_N_O, // status line drive value
	output logic STATUS_N_OE, // status line pulled low
	input wire logic LOAD_DONE_I, // load-complete line level
	output logic LOAD_DONE_O, // load-complete drive value
	output logic LOAD_DONE_OE, // load-complete pulled low
	output logic INIT_DONE_O, // init-done drive value
	output logic INIT_DONE_OE, // init-done pulled low
	output logic CFG_BUS_OE, // configuration bus driven
	output logic USER_IO_OE, // user I/O under design control
	output logic WEAK_PULLUP_EN, // weak pull-ups on user I/O
	output logic DEV_RESET // core held in reset
);
	localparam int SYNC_W = 27;

	ccs_pkg::ccs_state_t state_r;
	ccs_pkg::ccs_state_t state_nxt;
	ccs_pkg::ccs_ctrl_t ctrl_r;
	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic cbc_d_r;
	logic uic_d_r;
	logic restart_n_s;
	logic ce_n_s;
	logic status_n_s;
	logic load_done_s;
	logic cbc_s;
	logic uic_s;
	logic jtag_s;
	logic [3:0] scheme_s;
	logic [15:0] data_s;
	logic cbc_rise;
	logic uic_rise;
	logic fast_por;
	logic active_scheme;
	logic [4:0] width;
	logic [31:0] cnt_r;
	logic [31:0] por_lim;
	logic [31:0] len_r;
	logic [31:0] bitcnt_r;
	logic [31:0] bitcnt_nxt;
	logic [15:0] shift_r;
	logic [15:0] shift_nxt;
	logic hdr_edge;
	logic frame_err;
	logic data_done;
	logic reset_req;
	logic [3:0] osc_cnt_r;
	logic osc_tick_r;
	logic init_tick;
	logic [12:0] init_cnt_r;
	logic init_drive_r;
	logic wb_hit;
	logic [31:0] stat_word;

	// pins cross into the reference domain through two stages
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync1_r <= '0;
			sync2_r <= '0;
			cbc_d_r <= 1'b0;
			uic_d_r <= 1'b0;
		end else begin
			sync1_r <= {RESTART_N, CHAIN_ENABLE_N, STATUS_N_I, LOAD_DONE_I, CFG_BIT_CLOCK,
				USER_INIT_CLOCK, JTAG_CFG_SEL, SCHEME_SELECT, CFG_DATA};
			sync2_r <= sync1_r;
			cbc_d_r <= cbc_s;
			uic_d_r <= uic_s;
		end
	end

	assign {restart_n_s, ce_n_s, status_n_s, load_done_s, cbc_s, uic_s, jtag_s, scheme_s, data_s} = sync2_r;
	// edges found on the synchronised copies, data sampled with equal latency
	assign cbc_rise = cbc_s & ~cbc_d_r;
	assign uic_rise = uic_s & ~uic_d_r;

	// scheme decode; boundary-scan overrides the width, not the delay
	always_comb begin
		fast_por = 1'b0;
		active_scheme = 1'b0;
		width = ccs_pkg::W_SERIAL;
		case (scheme_s)
			ccs_pkg::SEL_AS_STD_A, ccs_pkg::SEL_AS_STD_B: active_scheme = 1'b1;
			ccs_pkg::SEL_AS_FAST_A, ccs_pkg::SEL_AS_FAST_B: begin
				active_scheme = 1'b1;
				fast_por = 1'b1;
			end
			ccs_pkg::SEL_AP_STD_A, ccs_pkg::SEL_AP_STD_B, ccs_pkg::SEL_AP_STD_C: begin
				active_scheme = 1'b1;
				width = ccs_pkg::W_WORD;
			end
			ccs_pkg::SEL_AP_FAST_A, ccs_pkg::SEL_AP_FAST_B: begin
				active_scheme = 1'b1;
				fast_por = 1'b1;
				width = ccs_pkg::W_WORD;
			end
			ccs_pkg::SEL_PS_FAST: fast_por = 1'b1;
			ccs_pkg::SEL_FPP_A, ccs_pkg::SEL_FPP_B, ccs_pkg::SEL_FPP_C: begin
				fast_por = 1'b1;
				width = ccs_pkg::W_BYTE;
			end
			default: fast_por = 1'b0;
		endcase
		if (jtag_s) begin
			active_scheme = 1'b0;
			width = ccs_pkg::W_SERIAL;
		end
	end

	// low end of each range so the reset never ends early
	assign por_lim = fast_por ? 32'(POR_FAST_CYCLES) : 32'(POR_STD_CYCLES);

	// data capture: shift in one word per configuration clock
	always_comb begin
		shift_nxt = shift_r;
		case (width)
			ccs_pkg::W_BYTE: shift_nxt = {shift_r[7:0], data_s[7:0]};
			ccs_pkg::W_WORD: shift_nxt = data_s;
			default: shift_nxt = {shift_r[14:0], data_s[0]};
		endcase
	end

	assign bitcnt_nxt = bitcnt_r + 32'(width);
	assign hdr_edge = (state_r == ccs_pkg::ST_CONFIG) && cbc_rise && (bitcnt_nxt == 32'(ccs_pkg::HDR_BITS));
	assign frame_err = hdr_edge && (shift_nxt != ccs_pkg::SYNC_WORD);
	assign data_done = (state_r == ccs_pkg::ST_CONFIG) && cbc_rise && (bitcnt_nxt >= len_r);
	assign reset_req = !restart_n_s || !status_n_s;

	// capture counters live only within configuration
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			shift_r <= 16'h0000;
			bitcnt_r <= 32'h0000_0000;
		end else if (state_r != ccs_pkg::ST_CONFIG) begin
			shift_r <= 16'h0000;
			bitcnt_r <= 32'h0000_0000;
		end else if (cbc_rise) begin
			shift_r <= shift_nxt;
			bitcnt_r <= bitcnt_nxt;
		end
	end

	// internal oscillator modelled as an enable from the reference clock
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			osc_cnt_r <= 4'h0;
			osc_tick_r <= 1'b0;
		end else if (osc_cnt_r == 4'(ccs_pkg::OSC_DIV - 1)) begin
			osc_cnt_r <= 4'h0;
			osc_tick_r <= 1'b1;
		end else begin
			osc_cnt_r <= osc_cnt_r + 4'h1;
			osc_tick_r <= 1'b0;
		end
	end

	// a stopped user clock stalls user-mode entry indefinitely
	assign init_tick = ctrl_r.user_clk_en ? uic_rise : osc_tick_r;

	// delay counter for power-on reset and error time-out
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cnt_r <= 32'h0000_0000;
		end else if (state_nxt != state_r) begin
			cnt_r <= 32'h0000_0000;
		end else if (state_r == ccs_pkg::ST_POR || state_r == ccs_pkg::ST_ERROR) begin
			cnt_r <= cnt_r + 32'h0000_0001;
		end
	end

	// initialization counter runs once load-complete is seen high
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			init_cnt_r <= 13'h0000;
		end else if (state_r != ccs_pkg::ST_INIT) begin
			init_cnt_r <= 13'h0000;
		end else if (load_done_s && init_tick) begin
			init_cnt_r <= init_cnt_r + 13'h0001;
		end
	end

	// sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ccs_pkg::ST_POR: begin
				if (cnt_r >= por_lim - 32'h0000_0001) begin
					state_nxt = ccs_pkg::ST_RESET;
				end
			end
			ccs_pkg::ST_RESET: begin
				if (restart_n_s && status_n_s) begin
					state_nxt = ccs_pkg::ST_CONFIG;
				end
			end
			ccs_pkg::ST_CONFIG: begin
				if (reset_req) begin
					state_nxt = ccs_pkg::ST_RESET;
				end else if (frame_err) begin
					state_nxt = ccs_pkg::ST_ERROR;
				end else if (data_done) begin
					state_nxt = ccs_pkg::ST_INIT;
				end
			end
			ccs_pkg::ST_ERROR: begin
				if (!restart_n_s) begin
					state_nxt = ccs_pkg::ST_RESET;
				end else if (ctrl_r.auto_restart && cnt_r >= 32'(ERR_TMO_CYCLES - 1)) begin
					state_nxt = ccs_pkg::ST_RESET;
				end
			end
			ccs_pkg::ST_INIT: begin
				if (reset_req) begin
					state_nxt = ccs_pkg::ST_RESET;
				end else if (init_cnt_r == 13'(INIT_CYCLES)) begin
					state_nxt = ccs_pkg::ST_USER;
				end
			end
			ccs_pkg::ST_USER: begin
				if (reset_req) begin
					state_nxt = ccs_pkg::ST_RESET;
				end
			end
			default: state_nxt = ccs_pkg::ST_POR;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_r <= ccs_pkg::ST_POR;
		end else begin
			state_r <= state_nxt;
		end
	end

	// init-done pulled low from the first good frame until user mode
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			init_drive_r <= 1'b0;
		end else if (state_nxt != ccs_pkg::ST_CONFIG && state_nxt != ccs_pkg::ST_INIT) begin
			init_drive_r <= 1'b0;
		end else if (hdr_edge && !frame_err && ctrl_r.init_done_en) begin
			init_drive_r <= 1'b1;
		end
	end

	// pin controls registered from the next state so they line up with state_r
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			STATUS_N_OE <= 1'b1;
			LOAD_DONE_OE <= 1'b1;
			CFG_BUS_OE <= 1'b0;
			USER_IO_OE <= 1'b0;
			WEAK_PULLUP_EN <= 1'b0;
			DEV_RESET <= 1'b1;
		end else begin
			STATUS_N_OE <= (state_nxt == ccs_pkg::ST_POR) || (state_nxt == ccs_pkg::ST_ERROR) ||
				(state_nxt == ccs_pkg::ST_RESET && !restart_n_s);
			LOAD_DONE_OE <= (state_nxt != ccs_pkg::ST_INIT) && (state_nxt != ccs_pkg::ST_USER);
			CFG_BUS_OE <= active_scheme && !(ce_n_s && !restart_n_s) &&
				(state_nxt == ccs_pkg::ST_POR || state_nxt == ccs_pkg::ST_CONFIG);
			USER_IO_OE <= (state_nxt == ccs_pkg::ST_USER);
			WEAK_PULLUP_EN <= (state_nxt != ccs_pkg::ST_POR) && (state_nxt != ccs_pkg::ST_USER);
			DEV_RESET <= (state_nxt == ccs_pkg::ST_POR) || (state_nxt == ccs_pkg::ST_RESET) ||
				(state_nxt == ccs_pkg::ST_ERROR);
		end
	end

	// open-drain lines only ever pull low
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			STATUS_N_O <= 1'b0;
			LOAD_DONE_O <= 1'b0;
			INIT_DONE_O <= 1'b0;
			INIT_DONE_OE <= 1'b0;
		end else begin
			STATUS_N_O <= 1'b0;
			LOAD_DONE_O <= 1'b0;
			INIT_DONE_O <= 1'b0;
			INIT_DONE_OE <= init_drive_r &&
				(state_nxt == ccs_pkg::ST_CONFIG || state_nxt == ccs_pkg::ST_INIT);
		end
	end

	// wishbone slave: one wait state, unmapped reads return zero
	assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign stat_word = {19'h00000, width, fast_por, init_drive_r, state_r};

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= wb_hit;
			if (wb_hit && !WB_WE_I) begin
				if (WB_ADR_I == ccs_pkg::ADDR_CTRL) begin
					WB_DAT_O <= {29'h00000000, ctrl_r};
				end else if (WB_ADR_I == ccs_pkg::ADDR_LEN) begin
					WB_DAT_O <= len_r;
				end else if (WB_ADR_I == ccs_pkg::ADDR_STAT) begin
					WB_DAT_O <= stat_word;
				end else if (WB_ADR_I == ccs_pkg::ADDR_BITS) begin
					WB_DAT_O <= bitcnt_r;
				end else begin
					WB_DAT_O <= 32'h0000_0000;
				end
			end
		end
	end

	// control register; options take effect at the next decision point
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_r <= ccs_pkg::CTRL_RST;
		end else if (wb_hit && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ccs_pkg::ADDR_CTRL) begin
			ctrl_r <= WB_DAT_I[2:0];
		end
	end

	// length register, byte lanes written one by one
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_len
			always_ff @(posedge REF_CLK or negedge RST_B) begin
				if (!RST_B) begin
					len_r[gi*8 +: 8] <= ccs_pkg::LEN_RST[gi*8 +: 8];
				end else if (wb_hit && WB_WE_I && WB_SEL_I[gi] && WB_ADR_I == ccs_pkg::ADDR_LEN) begin
					len_r[gi*8 +: 8] <= WB_DAT_I[gi*8 +: 8];
				end
			end
		end
	endgenerate
endmodule

/* tb/ccs_cfg_host.sv */
// far-side host model: link clock, data words and user start-up clock
`timescale 1ns/1ps
module ccs_cfg_host (
	output logic cfg_bit_clock, // link clock, still outside frames
	output logic [15:0] cfg_data, // configuration data bus
	output logic user_init_clock // user start-up clock
);
	// idle levels at time zero
	initial begin
		cfg_bit_clock = 1'b0;
		cfg_data = 16'h0000;
		user_init_clock = 1'b0;
	end

	// one 16-bit word, most significant slice first, width bits per link edge
	task automatic send_word(input logic [15:0] w, input int width);
		logic [15:0] t;
		for (int k = 0; k < 16 / width; k++) begin
			t = w << (k * width);
			cfg_data <= t >> (16 - width);
			#40 cfg_bit_clock <= 1'b1;
			#40 cfg_bit_clock <= 1'b0;
		end
		// released bus shows the inverse so a late capture cannot pass by luck
		cfg_data <= ~cfg_data;
		// one idle cycle so a following word never lands in the same step
		#10;
	endtask

	// start-up clock at 12.5 MHz, well under the ceiling
	task automatic user_clks(input int n);
		repeat (n) begin
			#40 user_init_clock <= 1'b1;
			#40 user_init_clock <= 1'b0;
		end
	endtask
endmodule

/* tb/ccs_top_assertions.sv */
// port checker for the configuration cycle sequencer
`timescale 1ns/1ps
module ccs_top_assertions #(
	parameter int POR_FAST_CYCLES = 100,
	parameter int POR_STD_CYCLES = 300,
	parameter int INIT_CYCLES = 3185
) (
	input wire logic REF_CLK, // clock
	input wire logic RST_B, // reset
	input wire logic RESTART_N, // restart
	input wire logic STATUS_N_I, // status wire
	input wire logic STATUS_N_OE, // status drive
	input wire logic LOAD_DONE_I, // load wire
	input wire logic LOAD_DONE_OE, // load drive
	input wire logic INIT_DONE_OE, // init-done drive
	input wire logic USER_IO_OE, // user mode
	input wire logic WEAK_PULLUP_EN, // pull-ups
	input wire logic DEV_RESET // core reset
);
	logic [31:0] cyc_r;
	logic [31:0] init_r;
	logic rel_r;
	// cycles since reset and since load-complete rose; 32 bits never wrap in a run
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cyc_r <= '0;
			init_r <= '0;
			rel_r <= 1'b0;
		end else begin
			cyc_r <= cyc_r + 1;
			init_r <= LOAD_DONE_I ? init_r + 1 : '0;
			rel_r <= rel_r | !STATUS_N_OE;
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);

	property p_por_len;
		$fell(STATUS_N_OE) && !rel_r |-> cyc_r >= POR_FAST_CYCLES && cyc_r <= POR_STD_CYCLES + 16;
	endproperty
	a_por_len: assert property (p_por_len) else $error("power-on delay out of range");
	property p_hold_rst;
		(!RESTART_N) [*6] |-> DEV_RESET && STATUS_N_OE;
	endproperty
	a_hold_rst: assert property (p_hold_rst) else $error("not in reset while restart low");
	property p_status_low;
		(!STATUS_N_I) [*6] |-> DEV_RESET;
	endproperty
	a_status_low: assert property (p_status_low) else $error("not in reset while status low");
	property p_restart_low;
		$fell(RESTART_N) |-> ##[1:6] (STATUS_N_OE && LOAD_DONE_OE && !USER_IO_OE && !INIT_DONE_OE);
	endproperty
	a_restart_low: assert property (p_restart_low) else $error("restart did not pull lines");
	property p_restart_rel;
		rel_r && $rose(RESTART_N) |-> ##[1:8] !STATUS_N_OE;
	endproperty
	a_restart_rel: assert property (p_restart_rel) else $error("status not released");
	property p_err_done;
		$rose(STATUS_N_OE) && RESTART_N |-> LOAD_DONE_OE && DEV_RESET;
	endproperty
	a_err_done: assert property (p_err_done) else $error("error released load-complete");
	property p_pullup;
		!DEV_RESET && !USER_IO_OE |-> WEAK_PULLUP_EN && !STATUS_N_OE;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-ups off before user mode");
	property p_user;
		$rose(USER_IO_OE) |-> init_r >= 2 * INIT_CYCLES && !INIT_DONE_OE && !WEAK_PULLUP_EN && !LOAD_DONE_OE;
	endproperty
	a_user: assert property (p_user) else $error("early or unclean user mode entry");

	c_user: cover property ($rose(USER_IO_OE));
	c_err: cover property ($rose(STATUS_N_OE) && RESTART_N);
	c_restart: cover property (rel_r && $rose(RESTART_N));
endmodule

bind ccs_top ccs_top_assertions #(.POR_FAST_CYCLES(POR_FAST_CYCLES), .POR_STD_CYCLES(POR_STD_CYCLES),
	.INIT_CYCLES(INIT_CYCLES)) u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .RESTART_N(RESTART_N),
	.STATUS_N_I(STATUS_N_I), .STATUS_N_OE(STATUS_N_OE), .LOAD_DONE_I(LOAD_DONE_I),
	.LOAD_DONE_OE(LOAD_DONE_OE), .INIT_DONE_OE(INIT_DONE_OE), .USER_IO_OE(USER_IO_OE),
	.WEAK_PULLUP_EN(WEAK_PULLUP_EN), .DEV_RESET(DEV_RESET));

/* tb/tb_top.sv */
// self-checking bench for the configuration cycle sequencer
`timescale 1ns/1ps
module tb_top;
	localparam int POR_F = 100;
	localparam int POR_S = 300;
	localparam int TMO = 200;
	localparam int INITC = 20;
	logic ref_clk, rst_b, wb_we, wb_cyc, wb_stb, wb_ack, restart_n, jtag_sel, chain_en_n;
	logic bit_clk, user_clk, st_oe, ld_oe, id_oe, bus_oe, io_oe, pu_en, dev_rst;
	logic [7:0] wb_adr;
	logic [31:0] wb_wdat, wb_rdat, rd;
	logic [3:0] wb_sel, scheme, pins;
	logic [15:0] cfg_data;
	int n_errors, checks, cnt;
	time t0;

	assign pins = {io_oe, id_oe, ld_oe, st_oe};
	always #5 ref_clk = ~ref_clk;
	ccs_cfg_host u_host (.cfg_bit_clock(bit_clk), .cfg_data(cfg_data), .user_init_clock(user_clk));
	// open-drain lines resolve against external pull-ups
	ccs_top #(.POR_FAST_CYCLES(POR_F), .POR_STD_CYCLES(POR_S), .ERR_TMO_CYCLES(TMO), .INIT_CYCLES(INITC)) u_dut (
		.REF_CLK(ref_clk), .RST_B(rst_b), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat),
		.WB_SEL_I(wb_sel), .WB_WE_I(wb_we), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_ACK_O(wb_ack),
		.RESTART_N(restart_n), .CHAIN_ENABLE_N(chain_en_n), .SCHEME_SELECT(scheme), .JTAG_CFG_SEL(jtag_sel),
		.CFG_BIT_CLOCK(bit_clk), .CFG_DATA(cfg_data), .USER_INIT_CLOCK(user_clk), .STATUS_N_I(~st_oe),
		.STATUS_N_O(), .STATUS_N_OE(st_oe), .LOAD_DONE_I(~ld_oe), .LOAD_DONE_O(), .LOAD_DONE_OE(ld_oe),
		.INIT_DONE_O(), .INIT_DONE_OE(id_oe), .CFG_BUS_OE(bus_oe), .USER_IO_OE(io_oe),
		.WEAK_PULLUP_EN(pu_en), .DEV_RESET(dev_rst));

	// value and count comparisons
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int n, input int lo, input int hi);
		checks++;
		if (n < lo || n > hi) begin
			n_errors++;
			$display("FAIL %0t count %0d outside %0d to %0d", $time, n, lo, hi);
		end
	endtask
	function automatic int el();
		return int'(($time - t0) / 10);
	endfunction

	// classic single wishbone cycle; held until ack is sampled, then released
	task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
		int t;
		@(posedge ref_clk);
		wb_adr <= a;
		wb_we <= we;
		wb_wdat <= d;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		t = 0;
		do begin
			@(posedge ref_clk);
			t++;
		end while (wb_ack !== 1'b1 && t < 50);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		if (t >= 50) begin
			n_errors++;
			$display("FAIL %0t no acknowledge", $time);
		end
	endtask

	// bounded wait for one open-drain or mode pin; cycles counted
	task automatic wait_pin(input int i, input logic v, output int n);
		n = 0;
		while (pins[i] !== v && n < 2000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n >= 2000) begin
			n_errors++;
			$display("FAIL %0t pin %0d never reached %b", $time, i, v);
		end
	endtask

	// restart pulse of 51 cycles, just over the shortest the host may give
	task automatic pulse_restart();
		@(posedge ref_clk);
		restart_n <= 1'b0;
		repeat (50) @(posedge ref_clk);
		#1;
		chk(32'({st_oe, ld_oe, io_oe, id_oe, dev_rst}), 32'h19);
		@(posedge ref_clk);
		restart_n <= 1'b1;
		wait_pin(0, 1'b0, cnt);
		chk_rng(cnt, 1, 8);
	endtask

	task automatic conclude();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// main sequence
	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		wb_adr = 8'h00;
		wb_wdat = 32'h0;
		wb_sel = 4'hf;
		wb_we = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		restart_n = 1'b1;
		jtag_sel = 1'b0;
		chain_en_n = 1'b0;
		scheme = ccs_pkg::SEL_AS_STD_A;
		n_errors = 0;
		checks = 0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		t0 = $time;
		// power-on reset with an active serial strap keeps its bus driven
		repeat (20) @(posedge ref_clk);
		#1;
		chk(32'({bus_oe, st_oe, ld_oe, io_oe}), 32'he);
		// chain enable high with restart low hands the bus to another master
		@(posedge ref_clk);
		chain_en_n <= 1'b1;
		restart_n <= 1'b0;
		repeat (50) @(posedge ref_clk);
		#1;
		chk(32'({bus_oe, st_oe, dev_rst}), 32'h3);
		@(posedge ref_clk);
		chain_en_n <= 1'b0;
		restart_n <= 1'b1;
		wb(ccs_pkg::ADDR_CTRL, 1'b0, 32'h0);
		chk(rd, 32'(ccs_pkg::CTRL_RST));
		wb(ccs_pkg::ADDR_LEN, 1'b0, 32'h0);
		chk(rd, ccs_pkg::LEN_RST);
		wb(ccs_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(32'(rd[7:0]), 32'h1);
		wb(8'h10, 1'b1, 32'hffff_ffff);
		wb(8'h10, 1'b0, 32'h0);
		chk(rd, 32'h0);
		wait_pin(0, 1'b0, cnt);
		chk_rng(el(), POR_S, POR_S + 12);
		chk(32'({pu_en, io_oe}), 32'h2);
		repeat (8) @(posedge ref_clk);
		wb(ccs_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(32'(rd[5:0]), 32'h4);
		// full serial load, then initialization on the internal oscillator
		wb(ccs_pkg::ADDR_CTRL, 1'b1, 32'h5);
		wb(ccs_pkg::ADDR_LEN, 1'b1, 32'h20);
		u_host.send_word(ccs_pkg::SYNC_WORD, 1);
		repeat (8) @(posedge ref_clk);
		#1;
		chk(32'(id_oe), 32'h1);
		// the bit count only lives while configuration is in progress
		wb(ccs_pkg::ADDR_BITS, 1'b0, 32'h0);
		chk(rd, 32'h10);
		u_host.send_word(16'h3c96, 1);
		wait_pin(1, 1'b0, cnt);
		t0 = $time;
		wb(ccs_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(32'(rd[5:0]), 32'h10);
		wait_pin(3, 1'b1, cnt);
		chk_rng(el(), INITC * 10 - 8, INITC * 10 + 12);
		chk(32'({id_oe, pu_en, dev_rst}), 32'h0);
		wb(ccs_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(32'(rd[5:0]), 32'h20);
		pulse_restart();
		// bad last header bit with auto restart: held, then released after the time-out
		repeat (8) @(posedge ref_clk);
		u_host.send_word(16'ha55b, 1);
		wait_pin(0, 1'b1, cnt);
		t0 = $time;
		chk(32'({ld_oe, dev_rst}), 32'h3);
		wait_pin(0, 1'b0, cnt);
		chk_rng(el(), TMO - 8, TMO + 4);
		// without auto restart the status line stays low until the host restarts
		wb(ccs_pkg::ADDR_CTRL, 1'b1, 32'h2);
		u_host.send_word(16'ha55b, 1);
		repeat (TMO + 100) @(posedge ref_clk);
		#1;
		chk(32'(st_oe), 32'h1);
		pulse_restart();
		repeat (8) @(posedge ref_clk);
		u_host.send_word(ccs_pkg::SYNC_WORD, 1);
		u_host.send_word(16'h3c96, 1);
		// initialization must wait on the user clock alone, counted exactly
		repeat (INITC * 10 + 50) @(posedge ref_clk);
		u_host.user_clks(INITC - 1);
		repeat (8) @(posedge ref_clk);
		#1;
		chk(32'(io_oe), 32'h0);
		// restart in mid-initialization while the host keeps its clock running
		@(posedge ref_clk);
		fork
			u_host.user_clks(8);
			pulse_restart();
		join
		u_host.send_word(ccs_pkg::SYNC_WORD, 1);
		u_host.send_word(16'h3c96, 1);
		u_host.user_clks(INITC - 1);
		repeat (8) @(posedge ref_clk);
		#1;
		chk(32'(io_oe), 32'h0);
		@(posedge ref_clk);
		u_host.user_clks(1);
		repeat (8) @(posedge ref_clk);
		#1;
		chk(32'(io_oe), 32'h1);
		// second reset: fast strap, boundary-scan forces single-bit width
		@(posedge ref_clk);
		rst_b <= 1'b0;
		scheme <= ccs_pkg::SEL_FPP_A;
		jtag_sel <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		t0 = $time;
		repeat (10) @(posedge ref_clk);
		#1;
		chk(32'(bus_oe), 32'h0);
		wb(ccs_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(32'(rd[12:7]), 32'h3);
		wait_pin(0, 1'b0, cnt);
		chk_rng(el(), POR_F, POR_F + 12);
		// byte-wide capture once boundary-scan lets go of the scheme choice
		@(posedge ref_clk);
		jtag_sel <= 1'b0;
		repeat (8) @(posedge ref_clk);
		u_host.send_word(ccs_pkg::SYNC_WORD, 8);
		wb(ccs_pkg::ADDR_BITS, 1'b0, 32'h0);
		chk(rd, 32'h10);
		wb(ccs_pkg::ADDR_STAT, 1'b0, 32'h0);
		chk(32'(rd[12:8]), 32'h8);
		conclude();
	end

	// hang guard, far beyond the few thousand cycles the run needs
	initial begin
		#200us;
		n_errors++;
		$display("FAIL %0t watchdog expired", $time);
		conclude();
	end
endmodule
